// ### rtl/l0umc_top.sv
// Purpose: user mode, reset and phase command registers of the first digital loop
// Assumes: APB slave, zero wait states, register index times four is the byte address
// Notes:   reset bits are levels held by software; phase bits clear themselves
//
// Notes on behaviour
// - The manual reference field in bits 6:5 selects reference A, B, C or D for codes 00 to 11, A after reset.
// - The switching mode field in bits 4:2 selects automatic revertive for 000 and automatic nonrevertive for 001.
// - Switching mode 010 is manual selection that falls back to another valid reference on failure.
// - Switching mode 011 is manual selection that falls back into holdover on failure.
// - Switching mode 100 is manual selection that stays on the chosen reference whatever its validity.
// - While the forced holdover bit 1 is set the loop stays in holdover, cleared after reset.
// - While the forced free run bit 0 is set the loop stays in free run, cleared after reset.
// - Bit 2 of the reset register clears the digital loop filter, for debug only.
// - Bit 1 of the reset register resets the tuning word history logic.
// - Bit 0 of the reset register resets the automatic synchronization logic.
// - Writing one to bit 2 of the phase register zeroes the phase offset, then the bit clears itself.
// - Writing one to bit 1 of the phase register subtracts the step once, then the bit clears itself.
// - Writing one to bit 0 of the phase register adds the step once, then the bit clears itself.
`timescale 1ns/10ps
`include "l0umc_defines.svh"
module l0umc_top
   import l0umc_pkg::*;
#(
   parameter int AW     = 16,
   parameter int OFFS_W = 32,
   parameter int STEP_W = 16
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [AW-1:0]     paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [STEP_W-1:0] phase_step,
   output l0umc_ref_e             manual_ref,
   output logic      [3:0]        manual_ref_onehot,
   output logic      [2:0]        switch_mode,
   output logic                   mode_auto_revertive,
   output logic                   mode_auto_nonrevertive,
   output logic                   mode_manual_ref_fallback,
   output logic                   mode_manual_holdover_fallback,
   output logic                   mode_manual_no_fallback,
   output logic                   mode_reserved,
   output logic                   force_holdover,
   output logic                   force_free_run,
   output logic                   loop_filter_clear,
   output logic                   tuning_word_history_reset,
   output logic                   autosync_reset,
   output logic      [OFFS_W-1:0] phase_offset
);

   typedef struct packed
   {
      l0umc_ref_e  mref;
      logic [2:0]  smode;
      logic        hold;
      logic        free;
      logic        rst_lf;
      logic        rst_tw;
      logic        rst_as;
      logic [2:0]  ph_pend;
      logic [5:0]  mode_flags;
      logic [31:0] rdata;
   } l0umc_state_s;

   l0umc_state_s st_reg;
   l0umc_state_s st_next;

   logic         sel_mode;
   logic         sel_rst;
   logic         sel_phase;
   logic         sel_stat;
   logic         sel_offs;
   logic         hit;
   logic         setup_cyc;
   logic         access_cyc;
   logic         wr_en;
   l0umc_phcmd_e ph_cmd;
   l0umc_byte_t  mode_rb;
   l0umc_byte_t  rst_rb;
   l0umc_byte_t  ph_rb;
   l0umc_byte_t  stat_rb;

   // one-hot decode of the switching mode, unused codes set the reserved flag bit 5
   function automatic logic [5:0] l0umc_mode_decode(input logic [2:0] code);
      logic [5:0] f;
      f = 6'h00;
      case (code)
         `L0UMC_SM_AUTO_REV:
         begin
            f[0] = 1'b1;
         end
         `L0UMC_SM_AUTO_NONREV:
         begin
            f[1] = 1'b1;
         end
         `L0UMC_SM_MAN_FALLBK:
         begin
            f[2] = 1'b1;
         end
         `L0UMC_SM_MAN_HOLDOVR:
         begin
            f[3] = 1'b1;
         end
         `L0UMC_SM_MAN_ONLY:
         begin
            f[4] = 1'b1;
         end
         default:
         begin
            f[5] = 1'b1;
         end
      endcase
      l0umc_mode_decode = f;
   endfunction : l0umc_mode_decode

   l0umc_apb_dec #(
      .AW        (AW)
   ) u_dec (
      .paddr     (paddr),
      .sel_mode  (sel_mode),
      .sel_rst   (sel_rst),
      .sel_phase (sel_phase),
      .sel_stat  (sel_stat),
      .sel_offs  (sel_offs),
      .hit       (hit)
   );

   // apb handshake, always ready
   assign setup_cyc  = psel & ~penable;
   assign access_cyc = psel & penable;
   assign pready     = 1'b1;
   assign pslverr    = access_cyc & ~hit;
   assign wr_en      = access_cyc & pwrite & hit & pstrb[0];

   // pending phase bits become one command, zero first
   always_comb
   begin
      if (st_reg.ph_pend[`L0UMC_PH_ZERO_BIT])
      begin
         ph_cmd = L0UMC_PH_ZERO;
      end
      else if (st_reg.ph_pend[`L0UMC_PH_DEC_BIT])
      begin
         ph_cmd = L0UMC_PH_DEC;
      end
      else if (st_reg.ph_pend[`L0UMC_PH_INC_BIT])
      begin
         ph_cmd = L0UMC_PH_INC;
      end
      else
      begin
         ph_cmd = L0UMC_PH_NONE;
      end
   end

   // read back values
   always_comb
   begin
      mode_rb = 8'h00;
      mode_rb[`L0UMC_MREF_MSB:`L0UMC_MREF_LSB]   = st_reg.mref;
      mode_rb[`L0UMC_SMODE_MSB:`L0UMC_SMODE_LSB] = st_reg.smode;
      mode_rb[`L0UMC_HOLD_BIT]                   = st_reg.hold;
      mode_rb[`L0UMC_FREE_BIT]                   = st_reg.free;
      rst_rb = 8'h00;
      rst_rb[`L0UMC_RST_LF_BIT] = st_reg.rst_lf;
      rst_rb[`L0UMC_RST_TW_BIT] = st_reg.rst_tw;
      rst_rb[`L0UMC_RST_AS_BIT] = st_reg.rst_as;
      ph_rb = 8'h00;
      ph_rb[2:0] = st_reg.ph_pend;
      stat_rb = 8'h00;
      stat_rb[`L0UMC_ST_RSVD_BIT] = st_reg.mode_flags[5];
      stat_rb[`L0UMC_ST_PEND_BIT] = |st_reg.ph_pend;
   end

   always_comb
   begin
      st_next = st_reg;
      // pending phase bits are consumed in one cycle
      st_next.ph_pend = 3'h0;
      if (wr_en && sel_mode)
      begin
         st_next.mref  = l0umc_ref_e'(pwdata[`L0UMC_MREF_MSB:`L0UMC_MREF_LSB]);
         st_next.smode = pwdata[`L0UMC_SMODE_MSB:`L0UMC_SMODE_LSB];
         st_next.hold  = pwdata[`L0UMC_HOLD_BIT];
         st_next.free  = pwdata[`L0UMC_FREE_BIT];
      end
      if (wr_en && sel_rst)
      begin
         st_next.rst_lf = pwdata[`L0UMC_RST_LF_BIT];
         st_next.rst_tw = pwdata[`L0UMC_RST_TW_BIT];
         st_next.rst_as = pwdata[`L0UMC_RST_AS_BIT];
      end
      // a new write wins over the self clear
      if (wr_en && sel_phase)
      begin
         st_next.ph_pend[`L0UMC_PH_ZERO_BIT] = pwdata[`L0UMC_PH_ZERO_BIT];
         st_next.ph_pend[`L0UMC_PH_DEC_BIT]  = pwdata[`L0UMC_PH_DEC_BIT];
         st_next.ph_pend[`L0UMC_PH_INC_BIT]  = pwdata[`L0UMC_PH_INC_BIT];
      end
      st_next.mode_flags = l0umc_mode_decode(st_next.smode);
      // read data captured in the setup cycle
      if (setup_cyc && !pwrite)
      begin
         if (sel_mode)
         begin
            st_next.rdata = {24'h000000, mode_rb};
         end
         else if (sel_rst)
         begin
            st_next.rdata = {24'h000000, rst_rb};
         end
         else if (sel_phase)
         begin
            st_next.rdata = {24'h000000, ph_rb};
         end
         else if (sel_stat)
         begin
            st_next.rdata = {24'h000000, stat_rb};
         end
         else if (sel_offs)
         begin
            st_next.rdata = 32'(phase_offset);
         end
         else
         begin
            st_next.rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg.mref       <= L0UMC_REF_A;
         st_reg.smode      <= 3'(`L0UMC_MODE_RESET >> `L0UMC_SMODE_LSB);
         st_reg.hold       <= 1'(`L0UMC_MODE_RESET >> `L0UMC_HOLD_BIT);
         st_reg.free       <= 1'(`L0UMC_MODE_RESET >> `L0UMC_FREE_BIT);
         st_reg.rst_lf     <= 1'(`L0UMC_RST_RESET >> `L0UMC_RST_LF_BIT);
         st_reg.rst_tw     <= 1'(`L0UMC_RST_RESET >> `L0UMC_RST_TW_BIT);
         st_reg.rst_as     <= 1'(`L0UMC_RST_RESET >> `L0UMC_RST_AS_BIT);
         st_reg.ph_pend    <= 3'(`L0UMC_PH_RESET);
         st_reg.mode_flags <= 6'h01;
         st_reg.rdata      <= 32'h00000000;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   l0umc_phase_acc #(
      .OFFS_W  (OFFS_W),
      .STEP_W  (STEP_W)
   ) u_acc (
      .pclk    (pclk),
      .presetn (presetn),
      .cmd     (ph_cmd),
      .step    (phase_step),
      .offset  (phase_offset)
   );

   // one-hot reference select
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ref
         assign manual_ref_onehot[g] = (st_reg.mref == l0umc_ref_e'(g));
      end
   endgenerate

   assign prdata                        = st_reg.rdata;
   assign manual_ref                    = st_reg.mref;
   assign switch_mode                   = st_reg.smode;
   assign mode_auto_revertive           = st_reg.mode_flags[0];
   assign mode_auto_nonrevertive        = st_reg.mode_flags[1];
   assign mode_manual_ref_fallback      = st_reg.mode_flags[2];
   assign mode_manual_holdover_fallback = st_reg.mode_flags[3];
   assign mode_manual_no_fallback       = st_reg.mode_flags[4];
   assign mode_reserved                 = st_reg.mode_flags[5];
   assign force_holdover                = st_reg.hold;
   assign force_free_run                = st_reg.free;
   assign loop_filter_clear             = st_reg.rst_lf;
   assign tuning_word_history_reset     = st_reg.rst_tw;
   assign autosync_reset                = st_reg.rst_as;

endmodule : l0umc_top

// ### rtl/l0umc_defines.svh
// Purpose: offsets, field positions, reset values and codes of the first loop user controls
// Assumes: register indices times four give the APB byte address
// Notes:   definitions only
`ifndef L0UMC_DEFINES_SVH
`define L0UMC_DEFINES_SVH

// register indices
`define L0UMC_IDX_USER_MODE   16'h0a22
`define L0UMC_IDX_RESET_CTL   16'h0a23
`define L0UMC_IDX_PHASE_CMD   16'h0a24
`define L0UMC_IDX_STATUS      16'h0a25
`define L0UMC_IDX_PHASE_OFFS  16'h0a26

// user mode fields
`define L0UMC_MREF_MSB        6
`define L0UMC_MREF_LSB        5
`define L0UMC_SMODE_MSB       4
`define L0UMC_SMODE_LSB       2
`define L0UMC_HOLD_BIT        1
`define L0UMC_FREE_BIT        0

// reset control fields
`define L0UMC_RST_LF_BIT      2
`define L0UMC_RST_TW_BIT      1
`define L0UMC_RST_AS_BIT      0

// phase command fields
`define L0UMC_PH_ZERO_BIT     2
`define L0UMC_PH_DEC_BIT      1
`define L0UMC_PH_INC_BIT      0

// status fields
`define L0UMC_ST_RSVD_BIT     0
`define L0UMC_ST_PEND_BIT     1

// reset values
`define L0UMC_MODE_RESET      8'h00
`define L0UMC_RST_RESET       8'h00
`define L0UMC_PH_RESET        8'h00

// switching mode codes
`define L0UMC_SM_AUTO_REV     3'h0
`define L0UMC_SM_AUTO_NONREV  3'h1
`define L0UMC_SM_MAN_FALLBK   3'h2
`define L0UMC_SM_MAN_HOLDOVR  3'h3
`define L0UMC_SM_MAN_ONLY     3'h4

`endif

// ### rtl/l0umc_pkg.sv
// Purpose: shared types of the first loop user controls
// Assumes: nothing
// Notes:   codes follow declaration order
package l0umc_pkg;

   typedef enum logic [1:0] {L0UMC_REF_A, L0UMC_REF_B, L0UMC_REF_C, L0UMC_REF_D} l0umc_ref_e;

   typedef enum logic [1:0] {L0UMC_PH_NONE, L0UMC_PH_ZERO, L0UMC_PH_DEC, L0UMC_PH_INC} l0umc_phcmd_e;

   typedef logic [7:0] l0umc_byte_t;

endpackage : l0umc_pkg

// ### rtl/l0umc_apb_dec.sv
// Purpose: APB address decode for the first loop user controls
// Assumes: word aligned byte addresses, index times four
// Notes:   pure decode, no state
`timescale 1ns/10ps
`include "l0umc_defines.svh"
module l0umc_apb_dec
   import l0umc_pkg::*;
#(
   parameter int AW = 16
)
(
   input  wire logic [AW-1:0] paddr,
   output logic               sel_mode,
   output logic               sel_rst,
   output logic               sel_phase,
   output logic               sel_stat,
   output logic               sel_offs,
   output logic               hit
);

   function automatic logic l0umc_match(input logic [AW-1:0] addr, input logic [15:0] idx);
      l0umc_match = (addr == AW'({idx, 2'b00}));
   endfunction : l0umc_match

   always_comb
   begin
      sel_mode  = l0umc_match(paddr, `L0UMC_IDX_USER_MODE);
      sel_rst   = l0umc_match(paddr, `L0UMC_IDX_RESET_CTL);
      sel_phase = l0umc_match(paddr, `L0UMC_IDX_PHASE_CMD);
      sel_stat  = l0umc_match(paddr, `L0UMC_IDX_STATUS);
      sel_offs  = l0umc_match(paddr, `L0UMC_IDX_PHASE_OFFS);
      hit       = sel_mode | sel_rst | sel_phase | sel_stat | sel_offs;
   end

endmodule : l0umc_apb_dec

// ### rtl/l0umc_phase_acc.sv
// Purpose: incremental phase offset accumulator of the first loop
// Assumes: one command per cycle, step size supplied from outside
// Notes:   offset is two's complement, wraps on overflow
`timescale 1ns/10ps
module l0umc_phase_acc
   import l0umc_pkg::*;
#(
   parameter int OFFS_W = 32,
   parameter int STEP_W = 16
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire l0umc_phcmd_e       cmd,
   input  wire logic [STEP_W-1:0]  step,
   output logic      [OFFS_W-1:0]  offset
);

   typedef struct packed
   {
      logic [OFFS_W-1:0] offs;
   } l0umc_acc_s;

   l0umc_acc_s acc_reg;
   l0umc_acc_s acc_next;

   always_comb
   begin
      acc_next = acc_reg;
      case (cmd)
         L0UMC_PH_ZERO:
         begin
            acc_next.offs = '0;
         end
         L0UMC_PH_DEC:
         begin
            acc_next.offs = acc_reg.offs - OFFS_W'(step);
         end
         L0UMC_PH_INC:
         begin
            acc_next.offs = acc_reg.offs + OFFS_W'(step);
         end
         default:
         begin
            acc_next = acc_reg;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_reg <= '0;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   assign offset = acc_reg.offs;

endmodule : l0umc_phase_acc

// ### test/l0umc_chk.sv
// Purpose: assertions on the first loop user control ports
// Assumes: byte address is register index times four
// Notes:   bound into l0umc_top
`timescale 1ns/10ps
`include "l0umc_defines.svh"
module l0umc_chk
   import l0umc_pkg::*;
#(
   parameter int AW     = 16,
   parameter int OFFS_W = 32,
   parameter int STEP_W = 16
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [AW-1:0]     paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [STEP_W-1:0] phase_step,
   input wire l0umc_ref_e        manual_ref,
   input wire logic [3:0]        manual_ref_onehot,
   input wire logic [2:0]        switch_mode,
   input wire logic              mode_auto_revertive,
   input wire logic              mode_auto_nonrevertive,
   input wire logic              mode_manual_ref_fallback,
   input wire logic              mode_manual_holdover_fallback,
   input wire logic              mode_manual_no_fallback,
   input wire logic              force_holdover,
   input wire logic              force_free_run,
   input wire logic              loop_filter_clear,
   input wire logic              tuning_word_history_reset,
   input wire logic              autosync_reset,
   input wire logic [OFFS_W-1:0] phase_offset
);
   logic              wr;
   logic              wr_mode;
   logic              wr_rst;
   logic              wr_ph;
   logic [OFFS_W-1:0] step_x;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign wr_mode = wr && paddr == AW'(`L0UMC_IDX_USER_MODE * 4);
   assign wr_rst = wr && paddr == AW'(`L0UMC_IDX_RESET_CTL * 4);
   assign wr_ph = wr && paddr == AW'(`L0UMC_IDX_PHASE_CMD * 4);
   assign step_x = OFFS_W'(phase_step);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_onehot; manual_ref_onehot == 4'h1 << manual_ref; endproperty
   property p_ref; wr_mode |=> manual_ref == $past(pwdata[6:5]); endproperty
   property p_mode; wr_mode |=> switch_mode == $past(pwdata[4:2]); endproperty
   property p_auto;
      mode_auto_revertive == (switch_mode == 3'h0) && mode_auto_nonrevertive == (switch_mode == 3'h1);
   endproperty
   property p_fbk; mode_manual_ref_fallback == (switch_mode == 3'h2); endproperty
   property p_hov; mode_manual_holdover_fallback == (switch_mode == 3'h3); endproperty
   property p_nofb; mode_manual_no_fallback == (switch_mode == 3'h4); endproperty
   property p_force; wr_mode |=> {force_holdover, force_free_run} == $past(pwdata[1:0]); endproperty
   property p_keep; !wr_mode |=> $stable({force_holdover, force_free_run}); endproperty
   property p_rst;
      wr_rst |=> {loop_filter_clear, tuning_word_history_reset, autosync_reset} == $past(pwdata[2:0]);
   endproperty
   property p_zero; wr_ph && pwdata[2] |=> ##1 phase_offset == '0; endproperty
   property p_dec; wr_ph && pwdata[2:0] == 3'h2 |=> ##1 phase_offset == $past(phase_offset) - $past(step_x); endproperty
   property p_inc; wr_ph && pwdata[2:0] == 3'h1 |=> ##1 phase_offset == $past(phase_offset) + $past(step_x); endproperty
   a_onehot: assert property (p_onehot) else $error("one-hot reference mismatch");
   a_ref: assert property (p_ref) else $error("manual reference not stored");
   a_mode: assert property (p_mode) else $error("switching mode not stored");
   a_auto: assert property (p_auto) else $error("automatic mode flags wrong");
   a_fbk: assert property (p_fbk) else $error("reference fallback flag wrong");
   a_hov: assert property (p_hov) else $error("holdover fallback flag wrong");
   a_nofb: assert property (p_nofb) else $error("no fallback flag wrong");
   a_force: assert property (p_force) else $error("force bits not stored");
   a_keep: assert property (p_keep) else $error("force bits changed");
   a_rst: assert property (p_rst) else $error("reset controls not stored");
   a_zero: assert property (p_zero) else $error("offset not zeroed");
   a_dec: assert property (p_dec) else $error("offset not decremented");
   a_inc: assert property (p_inc) else $error("offset not incremented");
   c_inc: cover property (wr_ph && pwdata[2:0] == 3'h1);
   c_zero: cover property (wr_ph && pwdata[2]);
   c_rsvd: cover property (switch_mode == 3'h7);
endmodule : l0umc_chk

bind l0umc_top l0umc_chk #(.AW(AW), .OFFS_W(OFFS_W), .STEP_W(STEP_W)) u_chk (.*);

// ### test/tb.sv
// Purpose: self-checking bench of the first loop user controls
// Assumes: zero wait state APB slave
// Notes:   reads noted in a queue, checked by a monitor
`timescale 1ns/10ps
`include "l0umc_defines.svh"
module tb
   import l0umc_pkg::*;
();
   localparam logic [15:0] A_MODE = 16'(`L0UMC_IDX_USER_MODE * 4);
   localparam logic [15:0] A_RST  = 16'(`L0UMC_IDX_RESET_CTL * 4);
   localparam logic [15:0] A_PH   = 16'(`L0UMC_IDX_PHASE_CMD * 4);
   logic        pclk, presetn, psel, penable, pwrite;
   logic [15:0] paddr, phase_step, s;
   logic [31:0] pwdata, r, eoff;
   logic [3:0]  pstrb;
   logic [7:0]  mlast;
   logic [2:0]  cmds [7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h4, 3'h1};
   wire  [31:0] prdata, poff;
   wire         pready, pslverr, fh, ffr, lfc, twr, asr;
   wire  [3:0]  onehot;
   wire  [2:0]  smode;
   wire  [5:0]  mflags;
   l0umc_ref_e  mref;
   int          fails, comparisons, cycles;
   logic [32:0] expq [$];

   l0umc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_step(phase_step), .manual_ref(mref), .manual_ref_onehot(onehot), .switch_mode(smode),
      .mode_auto_revertive(mflags[5]), .mode_auto_nonrevertive(mflags[4]), .mode_manual_ref_fallback(mflags[3]),
      .mode_manual_holdover_fallback(mflags[2]), .mode_manual_no_fallback(mflags[1]), .mode_reserved(mflags[0]),
      .force_holdover(fh), .force_free_run(ffr), .loop_filter_clear(lfc), .tuning_word_history_reset(twr),
      .autosync_reset(asr), .phase_offset(poff));

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] st);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [15:0] a, input logic [32:0] exp);
      expq.push_back(exp);
      apb(1'b0, a, 32'h0, 4'hf);
   endtask : rd

   task automatic tally_and_finish;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
      if ((psel & penable & pready & ~pwrite) === 1'b1 && expq.size() > 0)
         chk({pslverr, prdata}, expq.pop_front());

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, phase_step} = '0;
      {fails, comparisons, cycles, eoff} = '0;
      r = $urandom(32'heae0);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({mref, smode, mflags, fh, ffr, lfc, twr, asr}, {5'h0, 6'h20, 5'h0});
      chk(poff, 32'h0);
      rd(A_MODE, 33'h0);
      rd(A_RST, 33'h0);
      rd(A_PH, 33'h0);
      $display("test reset values done");
      for (int i = 0; i < 8; i++)
      begin
         r = $urandom();
         mlast = {1'b0, i[1:0], i[2:0], r[1:0]};
         apb(1'b1, A_MODE, {r[31:7], mlast[6:0]}, 4'hf);
         @(negedge pclk);
         chk({mref, onehot, smode, fh, ffr}, {i[1:0], 4'h1 << i[1:0], i[2:0], r[1:0]});
         chk(mflags, (i < 5) ? 6'h20 >> i : 6'h01);
         rd(A_MODE, {25'h0, mlast});
      end
      $display("test modes done");
      for (int i = 0; i < 8; i++)
      begin
         r = $urandom();
         apb(1'b1, A_RST, {r[31:3], i[2:0]}, 4'hf);
         @(negedge pclk);
         chk({lfc, twr, asr}, i[2:0]);
         rd(A_RST, {30'h0, i[2:0]});
      end
      $display("test reset controls done");
      foreach (cmds[i])
      begin
         s = 16'($urandom());
         phase_step <= s;
         apb(1'b1, A_PH, {29'h0, cmds[i]}, 4'hf);
         eoff = cmds[i][2] ? 32'h0 : cmds[i][1] ? eoff - 32'(s) : eoff + 32'(s);
         repeat (2) @(negedge pclk);
         chk(poff, eoff);
         rd(A_PH, 33'h0);
      end
      $display("test phase done");
      rd(16'h2800, {1'b1, 32'h0});
      apb(1'b1, A_MODE, 32'h0000_007f, 4'h0);
      apb(1'b1, 16'h2820, 32'h0000_00ff, 4'hf);
      rd(A_MODE, {25'h0, mlast});
      $display("test refusals done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({mref, smode, mflags, fh, ffr, lfc, twr, asr}, {5'h0, 6'h20, 5'h0});
      chk(poff, 32'h0);
      rd(A_RST, 33'h0);
      repeat (2) @(posedge pclk);
      chk(33'(expq.size()), 33'h0);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb
